/* File: jtp_regs.svh */
// Constants for the test access port: instruction codes, widths, bit places
`ifndef JTP_REGS_SVH
`define JTP_REGS_SVH

// ----------------------------------------------------------------------
// Register widths
// ----------------------------------------------------------------------
`define JTP_IR_W         4
`define JTP_DR_W         32
`define JTP_BSR_LEN      8
`define JTP_SEC_W        10

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define JTP_IR_EXTEST    4'h0
`define JTP_IR_JTAG_IDENTITY_WORD    4'h1
`define JTP_IR_USERCODE  4'h2
`define JTP_IR_SAMPLE    4'h3
`define JTP_IR_CHIP      4'h4
`define JTP_IR_PLL       4'h8
`define JTP_IR_BYPASS    4'hF
`define JTP_IR_CAPTURE   4'h1

// ----------------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------------
`define JTP_UF_W         14
`define JTP_UF_LSB       18
`define JTP_REV_W        18
`define JTP_SEC_NO_JTAG  0
`define JTP_SEC_NO_PLL   4
`define JTP_PLL_DEVRST   31
`define JTP_PLL_BOOTJ    30
`define JTP_PLL_RESET    32'h0000_0000

`endif

/* File: jtp_pkg.sv */
// Types shared by the test access port and its clock crossing
package jtp_pkg;
`include "jtp_regs.svh"

   // -------------------------------------------------------------------
   // Controller states, one-hot
   // -------------------------------------------------------------------
   typedef enum logic [15:0] {
      JTP_TLR    = 16'h0001,
      JTP_RTI    = 16'h0002,
      JTP_SEL_DR = 16'h0004,
      JTP_CAP_DR = 16'h0008,
      JTP_SH_DR  = 16'h0010,
      JTP_EX1_DR = 16'h0020,
      JTP_PA_DR  = 16'h0040,
      JTP_EX2_DR = 16'h0080,
      JTP_UPD_DR = 16'h0100,
      JTP_SEL_IR = 16'h0200,
      JTP_CAP_IR = 16'h0400,
      JTP_SH_IR  = 16'h0800,
      JTP_EX1_IR = 16'h1000,
      JTP_PA_IR  = 16'h2000,
      JTP_EX2_IR = 16'h4000,
      JTP_UPD_IR = 16'h8000
   } jtp_tap_state_t;

   // -------------------------------------------------------------------
   // State held on the test clock
   // -------------------------------------------------------------------
   typedef struct packed {
      jtp_tap_state_t              st;
      logic [`JTP_IR_W-1:0]        ir;
      logic [`JTP_IR_W-1:0]        ir_sh;
      logic [`JTP_DR_W-1:0]        dr;
      logic [`JTP_BSR_LEN-1:0]     bsr_sh;
      logic [`JTP_BSR_LEN-1:0]     bsr_upd;
      logic                        byp;
      logic                        tdo;
      logic                        tdo_oe_n;
      logic [`JTP_DR_W-1:0]        pll_hold;
      logic                        pll_tgl;
      logic                        chip_sel;
      logic                        chip_tms;
      logic                        chip_tdi;
      logic                        test_en;
   } jtp_tck_st_t;

   // -------------------------------------------------------------------
   // State held on the system clock
   // -------------------------------------------------------------------
   typedef struct packed {
      logic                        tgl_seen;
      logic [`JTP_DR_W-1:0]        pll;
   } jtp_clk_st_t;

endpackage : jtp_pkg

/* File: jtp_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/1ps
module jtp_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } jtp_sync_st_t;

   jtp_sync_st_t s_q;
   jtp_sync_st_t s_d;

   // First stage feeds only the second, to let metastability settle
   always_comb
   begin
      s_d    = s_q;
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   assign q = s_q.s2;

endmodule : jtp_sync

/* File: jtp_tap.sv */
// Boundary-scan test access port with chip path and PLL settings write
`timescale 1ns/1ps
`include "jtp_regs.svh"
module jtp_tap
#(
   parameter logic [3:0]  ID_VERSION  = 4'h0,           // Arbitrary value
   parameter logic [15:0] ID_PART     = 16'h0A5A,       // Arbitrary value
   parameter logic [10:0] ID_MAKER    = 11'h055,        // Arbitrary value
   parameter logic [17:0] SILICON_REV = 18'h0_0001      // Arbitrary value
)
(
   input  wire logic                      CLK,
   input  wire logic                      RESETN,
   input  wire logic                      TCK,
   input  wire logic                      TMS,
   input  wire logic                      TDI,
   output logic                           TDO,
   output logic                           TDO_OE_N,
   input  wire logic [`JTP_SEC_W-1:0]     SEC_CFG,
   input  wire logic [`JTP_UF_W-1:0]      USER_FIELD,
   input  wire logic                      USER_FIELD_VALID,
   input  wire logic [`JTP_BSR_LEN-1:0]   PIN_IN,
   output logic      [`JTP_BSR_LEN-1:0]   PIN_OUT,
   output logic                           PIN_TEST_EN,
   output logic                           CHIP_SEL,
   output logic                           CHIP_TMS,
   output logic                           CHIP_TDI,
   input  wire logic                      CHIP_TDO,
   output logic      [`JTP_DR_W-1:0]      PLL_SETTINGS,
   output logic                           DEV_RESET,
   output logic                           BOOT_FROM_JTAG
);

   localparam int SYNC_W = 3 + `JTP_SEC_W + `JTP_UF_W + `JTP_BSR_LEN;

   jtp_pkg::jtp_tck_st_t              t_q;
   jtp_pkg::jtp_tck_st_t              t_d;
   jtp_pkg::jtp_clk_st_t              c_q;
   jtp_pkg::jtp_clk_st_t              c_d;
   logic [SYNC_W-1:0]                 tck_in_s;
   logic                              trst_n;
   logic [`JTP_SEC_W-1:0]             sec_s;
   logic [`JTP_UF_W-1:0]              uf_s;
   logic                              uf_ok_s;
   logic                              dev_rst_s;
   logic [`JTP_BSR_LEN-1:0]           pin_s;
   logic                              tgl_s;
   logic [`JTP_DR_W-1:0]              id_word;
   logic [`JTP_DR_W-1:0]              user_word;

   // ------------------------------------------------------------------
   // Controller step
   // ------------------------------------------------------------------
   function automatic jtp_pkg::jtp_tap_state_t jtp_next
   (
      input jtp_pkg::jtp_tap_state_t s,
      input logic                    m
   );
      case (s)
         jtp_pkg::JTP_TLR:    jtp_next = m ? jtp_pkg::JTP_TLR
                                           : jtp_pkg::JTP_RTI;
         jtp_pkg::JTP_RTI:    jtp_next = m ? jtp_pkg::JTP_SEL_DR
                                           : jtp_pkg::JTP_RTI;
         jtp_pkg::JTP_SEL_DR: jtp_next = m ? jtp_pkg::JTP_SEL_IR
                                           : jtp_pkg::JTP_CAP_DR;
         jtp_pkg::JTP_CAP_DR: jtp_next = m ? jtp_pkg::JTP_EX1_DR
                                           : jtp_pkg::JTP_SH_DR;
         jtp_pkg::JTP_SH_DR:  jtp_next = m ? jtp_pkg::JTP_EX1_DR
                                           : jtp_pkg::JTP_SH_DR;
         jtp_pkg::JTP_EX1_DR: jtp_next = m ? jtp_pkg::JTP_UPD_DR
                                           : jtp_pkg::JTP_PA_DR;
         jtp_pkg::JTP_PA_DR:  jtp_next = m ? jtp_pkg::JTP_EX2_DR
                                           : jtp_pkg::JTP_PA_DR;
         jtp_pkg::JTP_EX2_DR: jtp_next = m ? jtp_pkg::JTP_UPD_DR
                                           : jtp_pkg::JTP_SH_DR;
         jtp_pkg::JTP_UPD_DR: jtp_next = m ? jtp_pkg::JTP_SEL_DR
                                           : jtp_pkg::JTP_RTI;
         jtp_pkg::JTP_SEL_IR: jtp_next = m ? jtp_pkg::JTP_TLR
                                           : jtp_pkg::JTP_CAP_IR;
         jtp_pkg::JTP_CAP_IR: jtp_next = m ? jtp_pkg::JTP_EX1_IR
                                           : jtp_pkg::JTP_SH_IR;
         jtp_pkg::JTP_SH_IR:  jtp_next = m ? jtp_pkg::JTP_EX1_IR
                                           : jtp_pkg::JTP_SH_IR;
         jtp_pkg::JTP_EX1_IR: jtp_next = m ? jtp_pkg::JTP_UPD_IR
                                           : jtp_pkg::JTP_PA_IR;
         jtp_pkg::JTP_PA_IR:  jtp_next = m ? jtp_pkg::JTP_EX2_IR
                                           : jtp_pkg::JTP_PA_IR;
         jtp_pkg::JTP_EX2_IR: jtp_next = m ? jtp_pkg::JTP_UPD_IR
                                           : jtp_pkg::JTP_SH_IR;
         jtp_pkg::JTP_UPD_IR: jtp_next = m ? jtp_pkg::JTP_SEL_DR
                                           : jtp_pkg::JTP_RTI;
         default:             jtp_next = jtp_pkg::JTP_TLR;
      endcase
   endfunction : jtp_next

   // ------------------------------------------------------------------
   // Crossings into the test clock
   // ------------------------------------------------------------------
   // Static straps and the system reset enter through two flops
   jtp_sync #(.W(SYNC_W)) u_tck_sync
   (
      .clk (TCK),
      .d   ({RESETN, SEC_CFG, USER_FIELD, USER_FIELD_VALID,
             c_q.pll[`JTP_PLL_DEVRST], PIN_IN}),
      .q   (tck_in_s)
   );

   assign {trst_n, sec_s, uf_s, uf_ok_s, dev_rst_s, pin_s} = tck_in_s;

   // Capture words
   assign id_word   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
   // Boot code loads the field after reset; hide it until then
   assign user_word = {(uf_ok_s && !dev_rst_s) ? uf_s
                                               : {`JTP_UF_W{1'b0}},
                       SILICON_REV};

   // ------------------------------------------------------------------
   // Test clock logic
   // ------------------------------------------------------------------
   // Controller, instruction and data paths
   always_comb
   begin
      t_d    = t_q;
      t_d.st = jtp_next(t_q.st, TMS);
      case (t_q.st)
         jtp_pkg::JTP_TLR:
         begin
            t_d.ir      = `JTP_IR_JTAG_IDENTITY_WORD;
            t_d.test_en = 1'b0;
         end
         jtp_pkg::JTP_CAP_IR: t_d.ir_sh = `JTP_IR_CAPTURE;
         jtp_pkg::JTP_SH_IR:  t_d.ir_sh = {TDI, t_q.ir_sh[`JTP_IR_W-1:1]};
         jtp_pkg::JTP_UPD_IR:
         begin
            t_d.ir      = t_q.ir_sh;
            t_d.test_en = (t_q.ir_sh == `JTP_IR_EXTEST);
         end
         jtp_pkg::JTP_CAP_DR:
         begin
            t_d.byp = 1'b0;
            case (t_q.ir)
               `JTP_IR_JTAG_IDENTITY_WORD:   t_d.dr = id_word;
               `JTP_IR_USERCODE: t_d.dr = user_word;
               `JTP_IR_PLL:      t_d.dr = t_q.pll_hold;
               `JTP_IR_EXTEST,
               `JTP_IR_SAMPLE:   t_d.bsr_sh = pin_s;
               default:          t_d.byp = 1'b0;
            endcase
         end
         jtp_pkg::JTP_SH_DR:
         begin
            case (t_q.ir)
               `JTP_IR_JTAG_IDENTITY_WORD,
               `JTP_IR_USERCODE,
               `JTP_IR_PLL:
                  t_d.dr = {TDI, t_q.dr[`JTP_DR_W-1:1]};
               `JTP_IR_EXTEST,
               `JTP_IR_SAMPLE:
                  t_d.bsr_sh = {TDI, t_q.bsr_sh[`JTP_BSR_LEN-1:1]};
               default:
                  t_d.byp = TDI;
            endcase
         end
         jtp_pkg::JTP_UPD_DR:
         begin
            // The word waits in a holding register for the system side
            if (t_q.ir == `JTP_IR_PLL && !sec_s[`JTP_SEC_NO_PLL])
            begin
               t_d.pll_hold = t_q.dr;
               t_d.pll_tgl  = !t_q.pll_tgl;
            end
            if (t_q.ir == `JTP_IR_EXTEST || t_q.ir == `JTP_IR_SAMPLE)
               t_d.bsr_upd = t_q.bsr_sh;
         end
         default:
            t_d.ir = t_q.ir;
      endcase

      // Inner port is parked in its reset while not selected
      t_d.chip_sel = (t_d.ir == `JTP_IR_CHIP)
                     && !sec_s[`JTP_SEC_NO_JTAG];
      t_d.chip_tms = t_d.chip_sel ? TMS : 1'b1;
      t_d.chip_tdi = t_d.chip_sel & TDI;

      // Output bit is the head of the path that shifts next
      t_d.tdo_oe_n = !(t_d.st == jtp_pkg::JTP_SH_DR ||
                       t_d.st == jtp_pkg::JTP_SH_IR);
      if (t_d.st == jtp_pkg::JTP_SH_IR)
         t_d.tdo = t_d.ir_sh[0];
      else if (t_d.chip_sel)
         t_d.tdo = CHIP_TDO;
      else
         case (t_d.ir)
            `JTP_IR_JTAG_IDENTITY_WORD,
            `JTP_IR_USERCODE,
            `JTP_IR_PLL:      t_d.tdo = t_d.dr[0];
            `JTP_IR_EXTEST,
            `JTP_IR_SAMPLE:   t_d.tdo = t_d.bsr_sh[0];
            default:          t_d.tdo = t_d.byp;
         endcase

      // System reset also clears the port
      if (!trst_n)
      begin
         t_d          = '0;
         t_d.st       = jtp_pkg::JTP_TLR;
         t_d.ir       = `JTP_IR_JTAG_IDENTITY_WORD;
         t_d.pll_hold = `JTP_PLL_RESET;
         t_d.tdo_oe_n = 1'b1;
         t_d.chip_tms = 1'b1;
      end
   end

   always_ff @(posedge TCK)
   begin
      t_q <= t_d;
   end

   assign TDO         = t_q.tdo;
   assign TDO_OE_N    = t_q.tdo_oe_n;
   assign PIN_OUT     = t_q.bsr_upd;
   assign PIN_TEST_EN = t_q.test_en;
   assign CHIP_SEL    = t_q.chip_sel;
   assign CHIP_TMS    = t_q.chip_tms;
   assign CHIP_TDI    = t_q.chip_tdi;

   // ------------------------------------------------------------------
   // System clock side of the PLL write
   // ------------------------------------------------------------------
   // Write event crosses as a toggle; the hold word is stable by then
   jtp_sync #(.W(1)) u_clk_sync
   (
      .clk (CLK),
      .d   (t_q.pll_tgl),
      .q   (tgl_s)
   );

   // Load on a toggle; a gated TCK must still deliver the toggle edge
   always_comb
   begin
      c_d          = c_q;
      c_d.tgl_seen = tgl_s;
      if (tgl_s != c_q.tgl_seen)
         c_d.pll = t_q.pll_hold;
      if (!RESETN)
      begin
         c_d.pll      = `JTP_PLL_RESET;
         c_d.tgl_seen = tgl_s;
      end
   end

   always_ff @(posedge CLK)
   begin
      c_q <= c_d;
   end

   assign PLL_SETTINGS   = c_q.pll;
   assign DEV_RESET      = c_q.pll[`JTP_PLL_DEVRST];
   assign BOOT_FROM_JTAG = c_q.pll[`JTP_PLL_BOOTJ];

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_tms_reset;
      @(posedge TCK) disable iff (!trst_n)
      TMS [*5] |=> (t_q.st == jtp_pkg::JTP_TLR);
   endproperty
   a_tms_reset: assert property (p_tms_reset)
      else $error("Five TMS highs did not reach reset");

   property p_onehot;
      @(posedge TCK) disable iff (!trst_n) $onehot(t_q.st);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("Controller state not one-hot");

   property p_ir_cap;
      @(posedge TCK) disable iff (!trst_n)
      (t_q.st == jtp_pkg::JTP_CAP_IR) |=>
         (t_q.ir_sh == `JTP_IR_CAPTURE);
   endproperty
   a_ir_cap: assert property (p_ir_cap)
      else $error("Instruction capture value wrong");

   property p_jtag_identity_word;
      @(posedge TCK) disable iff (!trst_n)
      (t_q.st == jtp_pkg::JTP_CAP_DR && t_q.ir == `JTP_IR_JTAG_IDENTITY_WORD) |=>
         (t_q.dr == id_word) && t_q.dr[0];
   endproperty
   a_jtag_identity_word: assert property (p_jtag_identity_word)
      else $error("Identity word not captured");

   property p_user;
      @(posedge TCK) disable iff (!trst_n)
      (t_q.st == jtp_pkg::JTP_CAP_DR && t_q.ir == `JTP_IR_USERCODE) |=>
         (t_q.dr[31:18] == ($past(uf_ok_s && !dev_rst_s) ? $past(uf_s)
                                                        : 14'h0000));
   endproperty
   a_user: assert property (p_user)
      else $error("User field wrong in user code");

   property p_pll_write;
      @(posedge TCK) disable iff (!trst_n)
      (t_q.st == jtp_pkg::JTP_UPD_DR && t_q.ir == `JTP_IR_PLL &&
       !sec_s[`JTP_SEC_NO_PLL]) |=>
         (t_q.pll_tgl != $past(t_q.pll_tgl)) &&
         (t_q.pll_hold == $past(t_q.dr));
   endproperty
   a_pll_write: assert property (p_pll_write)
      else $error("PLL word not taken on update");

   property p_pll_block;
      @(posedge TCK) disable iff (!trst_n)
      sec_s[`JTP_SEC_NO_PLL] |=> $stable(t_q.pll_tgl);
   endproperty
   a_pll_block: assert property (p_pll_block)
      else $error("PLL write passed while locked");

   property p_chip_block;
      @(posedge TCK) disable iff (!trst_n)
      sec_s[`JTP_SEC_NO_JTAG] |=> !t_q.chip_sel && t_q.chip_tms;
   endproperty
   a_chip_block: assert property (p_chip_block)
      else $error("Tile path open while locked");

   property p_pll_load;
      @(posedge CLK) disable iff (!RESETN)
      (tgl_s != c_q.tgl_seen) |=> (PLL_SETTINGS == $past(t_q.pll_hold));
   endproperty
   a_pll_load: assert property (p_pll_load)
      else $error("PLL settings not loaded after toggle");

   c_id_shift: cover property (@(posedge TCK) disable iff (!trst_n)
      t_q.ir == `JTP_IR_JTAG_IDENTITY_WORD && t_q.st == jtp_pkg::JTP_SH_DR);
   c_pll_load: cover property (@(posedge CLK) disable iff (!RESETN)
      tgl_s != c_q.tgl_seen);
   c_chip_on: cover property (@(posedge TCK) disable iff (!trst_n)
      t_q.chip_sel);

endmodule : jtp_tap

/* File: jtp_host.sv */
// Host model that drives the test access port serially
`timescale 1ns/1ps
module jtp_host
(
   output logic     tck,
   output logic     tms,
   output logic     tdi,
   input wire logic tdo
);
   // ------------------------------
   // Serial clocking
   // ------------------------------
   // TCK stands still between calls; idle TDI keeps toggling
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One TCK period; TDO is taken before the rise that moves it on
   task automatic step(input logic m, input logic d, output logic o);
      o = tdo;
      tms = m;
      tdi = d;
      #16 tck = 1'b1;
      #16 tck = 1'b0;
   endtask : step

   // Idle cycles; a gated host must give these after a PLL word
   task automatic idle(input int n);
      logic o;
      repeat (n) step(1'b0, ~tdi, o);
   endtask : idle

   // Five TMS-high cycles, then park in Run-Test/Idle
   task automatic tap_reset();
      logic o;
      repeat (5) step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
   endtask : tap_reset

   // Shift n bits LSB first through IR or DR, idle to idle
   task automatic shift(input logic ir, input logic [31:0] din,
                        input int n, output logic [31:0] dout);
      logic o;
      dout = '0;
      step(1'b1, ~tdi, o);
      if (ir)
         step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
      step(1'b0, ~tdi, o);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
   endtask : shift
endmodule : jtp_host

/* File: tb_top.sv */
// Self-checking bench for the test access port
`timescale 1ns/1ps
module tb_top;
   localparam logic [3:0]  VER   = 4'h3;      // Arbitrary value
   localparam logic [15:0] PART  = 16'h2C4B;  // Arbitrary value
   localparam logic [10:0] MAKER = 11'h1A6;   // Arbitrary value
   localparam logic [17:0] REV   = 18'h0_0005; // Arbitrary value
   logic        CLK, RESETN, TCK, TMS, TDI, TDO, TDO_OE_N;
   logic        USER_FIELD_VALID, PIN_TEST_EN, CHIP_SEL, CHIP_TDO;
   logic        DEV_RESET, BOOT_FROM_JTAG, CHIP_TMS, CHIP_TDI;
   logic [9:0]  SEC_CFG;
   logic [13:0] USER_FIELD;
   logic [7:0]  PIN_IN, PIN_OUT;
   logic [31:0] PLL_SETTINGS, d, w;
   int          fail_count, comparisons;

   jtp_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
             .SILICON_REV(REV)) uut
      (.CLK(CLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS), .TDI(TDI),
       .TDO(TDO), .TDO_OE_N(TDO_OE_N), .SEC_CFG(SEC_CFG),
       .USER_FIELD(USER_FIELD), .USER_FIELD_VALID(USER_FIELD_VALID),
       .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_TEST_EN(PIN_TEST_EN),
       .CHIP_SEL(CHIP_SEL), .CHIP_TMS(CHIP_TMS), .CHIP_TDI(CHIP_TDI),
       .CHIP_TDO(CHIP_TDO), .PLL_SETTINGS(PLL_SETTINGS),
       .DEV_RESET(DEV_RESET), .BOOT_FROM_JTAG(BOOT_FROM_JTAG));

   jtp_host host (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO));

   // ------------------------------
   // Checking and verdict
   // ------------------------------
   // Identity word built from the bench's own parameter values
   function automatic logic [31:0] id_word();
      return {VER, PART, MAKER, 1'b1};
   endfunction : id_word

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // ------------------------------
   // Clock and watchdog
   // ------------------------------
   initial
   begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   // Whole run is some tens of microseconds; ten times that is a hang
   initial
   begin
      #300_000;
      fail_count++;
      wrap_up();
   end

   // ------------------------------
   // Scenarios
   // ------------------------------
   initial
   begin
      RESETN = 1'b0;
      SEC_CFG = '0;
      USER_FIELD = '0;
      USER_FIELD_VALID = 1'b0;
      PIN_IN = '0;
      CHIP_TDO = 1'b1;
      void'($urandom(6));
      // TCK must run while reset is held so the port side resets too
      fork
         repeat (8) host.tap_reset();
         begin
            repeat (20) @(negedge CLK);
            RESETN = 1'b1;
         end
      join
      host.tap_reset();
      host.shift(1'b0, $urandom, 32, d);
      check(d, id_word(), "identity");
      check({31'h0, d[0]}, 32'h0000_0001, "id b0");
      check({31'h0, TDO_OE_N}, 32'h1, "oe idle");
      host.shift(1'b1, 32'h2, 4, d);
      check(d, 32'h0000_0001, "ir capture");
      // User code first unloaded, then loaded by boot code
      for (int v = 0; v < 2; v++)
      begin
         @(negedge CLK);
         USER_FIELD = 14'($urandom);
         USER_FIELD_VALID = v[0];
         host.idle(4);
         host.shift(1'b1, 32'h2, 4, d);
         host.shift(1'b0, 32'h0, 32, d);
         check(d, {v ? USER_FIELD : 14'h0, REV}, "user");
      end
      check(d[17:0], REV, "revision");
      // Bypass delays by one bit; then a TMS reset restores identity
      w = $urandom;
      host.shift(1'b1, 32'hF, 4, d);
      host.shift(1'b0, w, 32, d);
      check(d, {w[30:0], 1'b0}, "bypass");
      host.tap_reset();
      host.shift(1'b0, 32'h0, 32, d);
      check(d, id_word(), "tms reset");
      // Sample then external test: pins captured, update drives pins
      w = $urandom;
      foreach (w[i])
         if (i < 2)
         begin
            @(negedge CLK);
            PIN_IN = 8'($urandom);
            host.shift(1'b1, i ? 32'h3 : 32'h0, 4, d);
            host.shift(1'b0, w, 8, d);
            check(d, {24'h0, PIN_IN}, "boundary");
         end
      check({24'h0, PIN_OUT}, {24'h0, w[7:0]}, "pin out");
      check({31'h0, PIN_TEST_EN}, 32'h1, "test en");
      // Inner port path, then blocked by security bit 0
      host.shift(1'b1, 32'h4, 4, d);
      check({31'h0, CHIP_SEL}, 32'h1, "chip sel");
      check({31'h0, CHIP_TMS}, 32'h0, "chip tms");
      check({31'h0, CHIP_TDI}, {31'h0, TDI}, "chip tdi");
      host.shift(1'b0, 32'h0, 32, d);
      check(d, 32'hFFFF_FFFF, "chip tdo");
      @(negedge CLK);
      SEC_CFG = 10'h001;
      host.idle(4);
      host.shift(1'b1, 32'h4, 4, d);
      check({31'h0, CHIP_SEL}, 32'h0, "chip block");
      check({30'h0, CHIP_TMS, CHIP_TDI}, 32'h2, "chip park");
      host.shift(1'b0, 32'h0, 32, d);
      check(d, 32'h0, "chip block tdo");
      // PLL writes, back to back, then refused by security bit 4
      @(negedge CLK);
      SEC_CFG = 10'h000;
      host.shift(1'b1, 32'h8, 4, d);
      for (int k = 0; k < 3; k++)
      begin
         w = $urandom;
         host.shift(1'b0, w, 32, d);
         host.idle(100);
         check(PLL_SETTINGS, w, "pll");
         check({30'h0, DEV_RESET, BOOT_FROM_JTAG}, {30'h0, w[31:30]},
               "pll bits");
      end
      @(negedge CLK);
      SEC_CFG = 10'h010;
      host.idle(4);
      host.shift(1'b0, ~w, 32, d);
      check(d, w, "pll readback");
      host.idle(100);
      check(PLL_SETTINGS, w, "pll blocked");
      wrap_up();
   end
endmodule : tb_top
